/* File: verilog/rpf_profile_map.vh */
`ifndef RPF_PROFILE_MAP_VH
`define RPF_PROFILE_MAP_VH

// Register indices; byte address on the bus is four times the index
`define RPF_IDX_RANK_EN 16'h044D
`define RPF_IDX_BW_LOW 16'h044E
`define RPF_IDX_BW_MID 16'h044F
`define RPF_IDX_BW_TOP 16'h0450
`define RPF_IDX_DIV_LOW 16'h0451
`define RPF_IDX_DIV_MID 16'h0452
`define RPF_IDX_DIV_TOP 16'h0453
`define RPF_IDX_NUM_B0 16'h0454
`define RPF_IDX_NUM_B1 16'h0455
`define RPF_IDX_NUM_B2 16'h0456
`define RPF_IDX_MOD_B0 16'h0457
`define RPF_IDX_MOD_B1 16'h0458
`define RPF_IDX_MOD_B2 16'h0459
// Control register of this block: bit 0 commits staged values to the loop
`define RPF_IDX_COMMIT 16'h045A
// Status register of this block: live applied-value flags
`define RPF_IDX_STATUS 16'h045B

// Field positions
`define RPF_EN_BIT 0
`define RPF_RANK_LSB 1
`define RPF_RANK_MSB 2
`define RPF_FILT_BIT 1
`define RPF_BW16_BIT 0
`define RPF_COMMIT_BIT 0

// Writable bit masks per register; other bits are reserved
`define RPF_MASK_RANK_EN 8'h07
`define RPF_MASK_BW_TOP 8'h03
`define RPF_MASK_DIV_TOP 8'h03
`define RPF_MASK_FULL 8'hFF

// Reset value of every profile byte
`define RPF_RESET_BYTE 8'h00

`endif

/* File: verilog/rpf_wb_slave.v */
`timescale 1ns/1ps
// Classic Wishbone slave front end: one-cycle ack, registered read data
module rpf_wb_slave (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Register file side
	output wire wr_stb_o,
	output wire [13:0] idx_o,
	output wire [7:0] wdata_o,
	input wire [7:0] rdata_i
);
	wire req;

	// A request is new only while no ack is out, so each access acks once
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx_o = wb_adr_i[15:2];
	assign wdata_o = wb_dat_i[7:0];
	// Only lane 0 carries data; writes without it change nothing
	assign wr_stb_o = req & wb_we_i & wb_sel_i[0];

	// Ack and read data
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req & ~wb_we_i) begin
				wb_dat_o <= {24'h00_0000, rdata_i};
			end
		end
	end
endmodule

/* File: verilog/rpf_profile_regs.v */
`timescale 1ns/1ps
`include "rpf_profile_map.vh"
module rpf_profile_regs #(
	parameter BW_W = 17,
	parameter DIV_W = 18,
	parameter FRAC_W = 24
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// Applied settings toward the loop
	output reg ref_enable_o,
	output reg [1:0] ref_rank_o,
	output reg [BW_W-1:0] loop_bw_scale_o,
	output reg high_margin_filter_o,
	output reg [DIV_W:0] int_div_ratio_o,
	output reg [FRAC_W-1:0] frac_numerator_o,
	output reg [FRAC_W-1:0] frac_modulus_o,
	output reg frac_enable_o,
	output reg bw_scale_zero_o
);
	// Staged profile bytes, written by software
	reg [7:0] rank_en_reg;
	reg [7:0] bw_low_reg;
	reg [7:0] bw_mid_reg;
	reg [7:0] bw_top_reg;
	reg [7:0] div_low_reg;
	reg [7:0] div_mid_reg;
	reg [7:0] div_top_reg;
	reg [7:0] num_b0_reg;
	reg [7:0] num_b1_reg;
	reg [7:0] num_b2_reg;
	reg [7:0] mod_b0_reg;
	reg [7:0] mod_b1_reg;
	reg [7:0] mod_b2_reg;
	reg commit_reg;

	wire wr_stb;
	wire [13:0] idx;
	wire [7:0] wdata;
	reg [7:0] rdata_next;

	wire [BW_W-1:0] bw_staged;
	wire [DIV_W-1:0] div_staged;
	wire [FRAC_W-1:0] num_staged;
	wire [FRAC_W-1:0] mod_staged;

	// Index compare, truncating the map constant to the bus index width
	function hit;
		input [13:0] a;
		input [15:0] c;
		begin
			hit = (a == c[13:0]);
		end
	endfunction

	// Masked byte store so reserved bits stay zero
	function [7:0] wmask;
		input [7:0] d;
		input [7:0] m;
		begin
			wmask = d & m;
		end
	endfunction

	rpf_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.wr_stb_o(wr_stb),
		.idx_o(idx),
		.wdata_o(wdata),
		.rdata_i(rdata_next)
	);

	// Assemble staged multi-byte fields, low byte first
	assign bw_staged = {bw_top_reg[`RPF_BW16_BIT], bw_mid_reg, bw_low_reg};
	assign div_staged = {div_top_reg[1:0], div_mid_reg, div_low_reg};
	assign num_staged = {num_b2_reg, num_b1_reg, num_b0_reg};
	assign mod_staged = {mod_b2_reg, mod_b1_reg, mod_b0_reg};

	// Rank and enable byte; reserved bits are masked off on the way in
	always @(posedge clk_i) begin
		if (rst_i) begin
			rank_en_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_RANK_EN)) begin
			rank_en_reg <= wmask(wdata, `RPF_MASK_RANK_EN);
		end
	end

	// Bandwidth factor, low byte
	always @(posedge clk_i) begin
		if (rst_i) begin
			bw_low_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_BW_LOW)) begin
			bw_low_reg <= wdata;
		end
	end

	// Bandwidth factor, middle byte
	always @(posedge clk_i) begin
		if (rst_i) begin
			bw_mid_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_BW_MID)) begin
			bw_mid_reg <= wdata;
		end
	end

	// Bandwidth top bit and filter select; upper bits reserved
	always @(posedge clk_i) begin
		if (rst_i) begin
			bw_top_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_BW_TOP)) begin
			bw_top_reg <= wmask(wdata, `RPF_MASK_BW_TOP);
		end
	end

	// Integer divider, low byte
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_low_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_DIV_LOW)) begin
			div_low_reg <= wdata;
		end
	end

	// Integer divider, middle byte
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_mid_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_DIV_MID)) begin
			div_mid_reg <= wdata;
		end
	end

	// Integer divider, top two bits; the rest reserved
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_top_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_DIV_TOP)) begin
			div_top_reg <= wmask(wdata, `RPF_MASK_DIV_TOP);
		end
	end

	// Fraction numerator, byte 0
	always @(posedge clk_i) begin
		if (rst_i) begin
			num_b0_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_NUM_B0)) begin
			num_b0_reg <= wdata;
		end
	end

	// Fraction numerator, byte 1
	always @(posedge clk_i) begin
		if (rst_i) begin
			num_b1_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_NUM_B1)) begin
			num_b1_reg <= wdata;
		end
	end

	// Fraction numerator, byte 2
	always @(posedge clk_i) begin
		if (rst_i) begin
			num_b2_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_NUM_B2)) begin
			num_b2_reg <= wdata;
		end
	end

	// Fraction modulus, byte 0
	always @(posedge clk_i) begin
		if (rst_i) begin
			mod_b0_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_MOD_B0)) begin
			mod_b0_reg <= wdata;
		end
	end

	// Fraction modulus, byte 1
	always @(posedge clk_i) begin
		if (rst_i) begin
			mod_b1_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_MOD_B1)) begin
			mod_b1_reg <= wdata;
		end
	end

	// Fraction modulus, byte 2
	always @(posedge clk_i) begin
		if (rst_i) begin
			mod_b2_reg <= `RPF_RESET_BYTE;
		end else if (wr_stb & hit(idx, `RPF_IDX_MOD_B2)) begin
			mod_b2_reg <= wdata;
		end
	end

	// Commit strobe: a write with bit 0 set raises it for one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			commit_reg <= 1'b0;
		end else begin
			commit_reg <= wr_stb & hit(idx, `RPF_IDX_COMMIT) & wdata[`RPF_COMMIT_BIT];
		end
	end

	// Applied enable; every applied field swaps in on the same commit
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_enable_o <= 1'b0;
		end else if (commit_reg) begin
			ref_enable_o <= rank_en_reg[`RPF_EN_BIT];
		end
	end

	// Applied rank, so a half-written profile never reaches the loop
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_rank_o <= 2'b00;
		end else if (commit_reg) begin
			ref_rank_o <= rank_en_reg[`RPF_RANK_MSB:`RPF_RANK_LSB];
		end
	end

	// Applied bandwidth factor, whole 17 bits at once
	always @(posedge clk_i) begin
		if (rst_i) begin
			loop_bw_scale_o <= {BW_W{1'b0}};
		end else if (commit_reg) begin
			loop_bw_scale_o <= bw_staged;
		end
	end

	// Applied filter select
	always @(posedge clk_i) begin
		if (rst_i) begin
			high_margin_filter_o <= 1'b0;
		end else if (commit_reg) begin
			high_margin_filter_o <= bw_top_reg[`RPF_FILT_BIT];
		end
	end

	// Stored value is ratio minus one, so zero gives one
	always @(posedge clk_i) begin
		if (rst_i) begin
			int_div_ratio_o <= {{DIV_W{1'b0}}, 1'b1};
		end else if (commit_reg) begin
			int_div_ratio_o <= {1'b0, div_staged} + {{DIV_W{1'b0}}, 1'b1};
		end
	end

	// Applied numerator
	always @(posedge clk_i) begin
		if (rst_i) begin
			frac_numerator_o <= {FRAC_W{1'b0}};
		end else if (commit_reg) begin
			frac_numerator_o <= num_staged;
		end
	end

	// Applied modulus
	always @(posedge clk_i) begin
		if (rst_i) begin
			frac_modulus_o <= {FRAC_W{1'b0}};
		end else if (commit_reg) begin
			frac_modulus_o <= mod_staged;
		end
	end

	// Zero modulus bypasses the fraction entirely
	always @(posedge clk_i) begin
		if (rst_i) begin
			frac_enable_o <= 1'b0;
		end else if (commit_reg) begin
			frac_enable_o <= (mod_staged != {FRAC_W{1'b0}});
		end
	end

	// Zero factor is only flagged; keeping it nonzero is software's duty
	always @(posedge clk_i) begin
		if (rst_i) begin
			bw_scale_zero_o <= 1'b1;
		end else if (commit_reg) begin
			bw_scale_zero_o <= (bw_staged == {BW_W{1'b0}});
		end
	end

	// Read mux; unmapped indices and reserved bits read zero
	always @* begin
		rdata_next = 8'h00;
		case (1'b1)
			hit(idx, `RPF_IDX_RANK_EN): rdata_next = rank_en_reg;
			hit(idx, `RPF_IDX_BW_LOW): rdata_next = bw_low_reg;
			hit(idx, `RPF_IDX_BW_MID): rdata_next = bw_mid_reg;
			hit(idx, `RPF_IDX_BW_TOP): rdata_next = bw_top_reg;
			hit(idx, `RPF_IDX_DIV_LOW): rdata_next = div_low_reg;
			hit(idx, `RPF_IDX_DIV_MID): rdata_next = div_mid_reg;
			hit(idx, `RPF_IDX_DIV_TOP): rdata_next = div_top_reg;
			hit(idx, `RPF_IDX_NUM_B0): rdata_next = num_b0_reg;
			hit(idx, `RPF_IDX_NUM_B1): rdata_next = num_b1_reg;
			hit(idx, `RPF_IDX_NUM_B2): rdata_next = num_b2_reg;
			hit(idx, `RPF_IDX_MOD_B0): rdata_next = mod_b0_reg;
			hit(idx, `RPF_IDX_MOD_B1): rdata_next = mod_b1_reg;
			hit(idx, `RPF_IDX_MOD_B2): rdata_next = mod_b2_reg;
			hit(idx, `RPF_IDX_STATUS): rdata_next = {5'b0_0000, bw_scale_zero_o,
				frac_enable_o, ref_enable_o};
			default: rdata_next = 8'h00;
		endcase
	end
endmodule

/* File: verif/rpf_profile_props.sv */
`timescale 1ns/1ps
// Watches the bus handshake and the applied loop settings
module rpf_profile_chk #(
	parameter BW_W = 17,
	parameter DIV_W = 18,
	parameter FRAC_W = 24
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire [15:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// Applied settings
	input wire [BW_W-1:0] loop_bw_scale_o,
	input wire [DIV_W:0] int_div_ratio_o,
	input wire [FRAC_W-1:0] frac_modulus_o,
	input wire frac_enable_o,
	input wire bw_scale_zero_o
);
	// A commit taken on this edge; the only cause of applied changes
	wire cmt = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_dat_i[0]
		&& wb_adr_i == 16'h1168;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_ratio_nonzero: assert property (int_div_ratio_o != 0)
		else $error("division ratio zero");
	a_frac_bypass: assert property (frac_enable_o == (frac_modulus_o != 0))
		else $error("fraction enable wrong");
	a_bw_zero_flag: assert property (bw_scale_zero_o == (loop_bw_scale_o == 0))
		else $error("zero factor flag wrong");
	a_bw_whole: assert property ($changed(loop_bw_scale_o) |-> $past(cmt, 2))
		else $error("factor changed without commit");
	a_div_whole: assert property ($changed(int_div_ratio_o) |-> $past(cmt, 2))
		else $error("ratio changed without commit");
endmodule
bind rpf_profile_regs rpf_profile_chk #(.BW_W(BW_W), .DIV_W(DIV_W), .FRAC_W(FRAC_W)) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_sel_i(wb_sel_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.loop_bw_scale_o(loop_bw_scale_o),
	.int_div_ratio_o(int_div_ratio_o),
	.frac_modulus_o(frac_modulus_o),
	.frac_enable_o(frac_enable_o),
	.bw_scale_zero_o(bw_scale_zero_o)
);

/* File: verif/rpf_profile_regs_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the profile register bank
module rpf_profile_regs_tb;
	// Drive and observe
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, ref_enable_o, high_margin_filter_o, frac_enable_o, bw_scale_zero_o;
	wire [1:0] ref_rank_o;
	wire [16:0] loop_bw_scale_o;
	wire [18:0] int_div_ratio_o;
	wire [23:0] frac_numerator_o, frac_modulus_o;
	int err_total = 0, samples_checked = 0, cycles = 0;
	logic [31:0] seed = 32'h0000_5638;
	logic [7:0] m [13];
	logic [7:0] q;
	rpf_profile_regs u_dut (.*);
	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	// Watchdog: a lost ack must not hang the run
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			conclude();
		end
	end
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Writable bits per byte; the rest are reserved
	function automatic [7:0] mask(input int i);
		mask = (i == 0) ? 8'h07 : (i == 3 || i == 6) ? 8'h03 : 8'hff;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {24'h00_0000, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Applied outputs against the last committed bytes
	task automatic applied();
		chk("enable", ref_enable_o, m[0][0]);
		chk("rank", ref_rank_o, m[0][2:1]);
		chk("bw", loop_bw_scale_o, {m[3][0], m[2], m[1]});
		chk("filter", high_margin_filter_o, m[3][1]);
		chk("ratio", int_div_ratio_o, {m[6][1:0], m[5], m[4]} + 1);
		chk("num", frac_numerator_o, {m[9], m[8], m[7]});
		chk("mod", frac_modulus_o, {m[12], m[11], m[10]});
		chk("frac_en", frac_enable_o, {m[12], m[11], m[10]} != 0);
		chk("bw_zero", bw_scale_zero_o, {m[3][0], m[2], m[1]} == 0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		foreach (m[k]) m[k] = 8'h00;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		applied();
		for (int k = 0; k < 13; k++) begin
			wb(1'b0, 14'h044D + k, 8'h00);
			chk("reset byte", q, 8'h00);
		end
		$display("test reset done");
		// Random bytes stay staged until the commit
		for (int k = 0; k < 13; k++) begin
			seed = lfsr(seed);
			// Forced top bits keep the factor nonzero, well above 50 Hz, filter set
			wb(1'b1, 14'h044D + k, seed[7:0] | mask(k + 1));
			m[k] = (seed[7:0] | mask(k + 1)) & mask(k);
			wb(1'b0, 14'h044D + k, 8'h00);
			chk("byte", q, m[k]);
		end
		chk("staged", int_div_ratio_o, 1);
		wb(1'b1, 14'h045A, 8'h01);
		#1;
		applied();
		wb(1'b1, 14'h0400, 8'ha5);
		wb(1'b0, 14'h0400, 8'h00);
		chk("unmapped", q, 8'h00);
		$display("test random commit done");
		// Every rank code with zero divider and zero modulus
		for (int k = 4; k < 13; k++) begin
			wb(1'b1, 14'h044D + k, 8'h00);
			m[k] = 8'h00;
		end
		for (int r = 0; r < 4; r++) begin
			m[0] = {5'h00, r[1:0], r[0]};
			wb(1'b1, 14'h044D, m[0]);
			wb(1'b1, 14'h045A, 8'h01);
			#1;
			applied();
		end
		wb(1'b0, 14'h045B, 8'h00);
		chk("status", q, {5'h00, {m[3][0], m[2], m[1]} == 0, 1'b0, m[0][0]});
		$display("test rank codes done");
		// Lane 0 disabled write, a staged modulus byte write, then a commit with bit 0 clear: no applied output moves
		wb_sel_i <= 4'he;
		wb(1'b1, 14'h044D, 8'h00);
		wb_sel_i <= 4'hf;
		wb(1'b1, 14'h0459, 8'h5a);
		wb(1'b1, 14'h045A, 8'h00);
		#1;
		applied();
		wb(1'b0, 14'h044D, 8'h00);
		chk("sel0 write", q, m[0]);
		wb(1'b0, 14'h045A, 8'h00);
		chk("commit reads", q, 8'h00);
		$display("test refusals done");
		conclude();
	end
endmodule
